// ===== cpu_instr_pkg.sv
// Shared types and constants of the instruction semantics block
package cpu_instr_pkg;

    // ****************************************
    // Instruction classes, opcode[7:3]
    // ****************************************
    typedef enum logic [4:0] {
        OP_NOP = 5'b00000,
        OP_MUL = 5'b00001,
        OP_DIV = 5'b00010,
        OP_DIVL = 5'b00011,
        OP_CMPD = 5'b00100,
        OP_CMPI = 5'b00101,
        OP_JBS = 5'b00110,
        OP_JBC = 5'b00111,
        OP_MASK = 5'b01000,
        OP_WIDEN = 5'b01001,
        OP_ARITH_SHIFT_RIGHT_OP = 5'b01010,
        OP_PUSH_AND_CALL_OP = 5'b01011,
        OP_CTXSW = 5'b01100,
        OP_RET = 5'b01101,
        OP_TRAP = 5'b01110,
        OP_INIT = 5'b01111,
        OP_WDT = 5'b10000,
        OP_WDTSRV = 5'b10001,
        OP_INV = 5'b10010,
        OP_INERT_POWERDOWN_OP = 5'b10011
    } op_t;

    typedef enum logic [1:0] {
        MD_MUL = 2'b00,
        MD_DIV = 2'b01,
        MD_DIVL = 2'b10
    } md_mode_t;

    // Opcode field positions
    localparam int OPC_CLASS_LSB = 3;
    localparam int OPC_LONG_BIT = 1;
    localparam int OPC_VARIANT_BIT = 0;

    // Values after reset, divide step count and compare steps
    localparam logic WDT_ON_RESET = 1'b1;
    localparam logic INIT_LOCK_RESET = 1'b0;
    localparam logic [5:0] DIV_STEPS = 6'h20;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] opcode;
        logic [15:0] opnd_a;
        logic [15:0] opnd_b;
        logic [3:0] bit_pos;
        logic [7:0] imm;
    } instr_t;

    typedef struct packed {
        logic [31:0] muldiv_pair;
        logic [15:0] stack_top;
        logic [15:0] stack_next;
    } core_t;

    typedef struct packed {
        logic len4;
        logic illegal;
        logic wr_reg;
        logic [15:0] reg_val;
        logic wr_md;
        logic [31:0] md_val;
        logic push;
        logic [15:0] push_val;
        logic [1:0] pop_cnt;
        logic branch;
        logic [15:0] target;
        logic flag_eq;
        logic flag_neg;
        logic flag_carry;
        logic trap;
        logic [7:0] trap_num;
        logic div_zero;
    } res_t;

endpackage

// ===== muldiv_unit.sv
// Multiply and iterative divide unit on the multiply/divide register pair
`timescale 1ns/10ps
module muldiv_unit import cpu_instr_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_core_n,
    input wire logic start,
    input wire md_mode_t mode,
    input wire logic is_signed,
    input wire logic [31:0] md_in,
    input wire logic [15:0] opnd_a,
    input wire logic [15:0] opnd_b,
    output logic busy,
    output logic done,
    output logic [31:0] md_out,
    output logic div_zero
);
    logic [31:0] num;
    logic [16:0] rem;
    logic [15:0] dvs;
    logic neg_q;
    logic neg_r;
    logic [5:0] cnt;
    logic [31:0] dvd;
    logic [16:0] rem_sh;
    logic [31:0] q_fix;
    logic [15:0] r_fix;

    // Dividend from the low half alone or from the whole pair
    always_comb begin
        dvd = md_in;
        if (mode == MD_DIV) begin
            dvd = is_signed ? {{16{md_in[15]}}, md_in[15:0]} : {16'h0000, md_in[15:0]};
        end
    end

    // One restoring step per cycle
    assign rem_sh = {rem[15:0], num[31]};
    assign q_fix = neg_q ? 32'h0000_0000 - num : num;
    assign r_fix = neg_r ? 16'h0000 - rem[15:0] : rem[15:0];

    // Sequencer; multiply answers in one cycle, divides take 32 steps
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            md_out <= 32'h0000_0000;
            div_zero <= 1'b0;
            num <= 32'h0000_0000;
            rem <= 17'h0_0000;
            dvs <= 16'h0000;
            neg_q <= 1'b0;
            neg_r <= 1'b0;
            cnt <= 6'h00;
        end else begin
            done <= 1'b0;
            if (start && mode == MD_MUL) begin
                // Product of the two register operands
                md_out <= is_signed ? {{16{opnd_a[15]}}, opnd_a} * {{16{opnd_b[15]}}, opnd_b}
                    : {16'h0000, opnd_a} * {16'h0000, opnd_b};
                div_zero <= 1'b0;
                done <= 1'b1;
            end else if (start && opnd_a == 16'h0000) begin
                // Zero divisor: pair left untouched, flag raised
                md_out <= md_in;
                div_zero <= 1'b1;
                done <= 1'b1;
            end else if (start) begin
                busy <= 1'b1;
                div_zero <= 1'b0;
                cnt <= DIV_STEPS;
                rem <= 17'h0_0000;
                num <= (is_signed && dvd[31]) ? 32'h0000_0000 - dvd : dvd;
                dvs <= (is_signed && opnd_a[15]) ? 16'h0000 - opnd_a : opnd_a;
                neg_q <= is_signed && (dvd[31] ^ opnd_a[15]);
                neg_r <= is_signed && dvd[31];
            end else if (busy && cnt != 6'h00) begin
                cnt <= cnt - 6'h01;
                if (rem_sh >= {1'b0, dvs}) begin
                    rem <= rem_sh - {1'b0, dvs};
                    num <= {num[30:0], 1'b1};
                end else begin
                    rem <= rem_sh;
                    num <= {num[30:0], 1'b0};
                end
            end else if (busy) begin
                // Remainder to the high half, quotient to the low half
                busy <= 1'b0;
                done <= 1'b1;
                md_out <= {r_fix, q_fix[15:0]};
            end
        end
    end
endmodule

// ===== bit_field_unit.sv
// Combinational word and bit manipulation for the register operand
`timescale 1ns/10ps
module bit_field_unit import cpu_instr_pkg::*; (
    input wire op_t op,
    input wire logic variant,
    input wire logic [15:0] opnd_a,
    input wire logic [15:0] opnd_b,
    input wire logic [3:0] bit_pos,
    output logic bit_val,
    output logic [15:0] new_val
);
    logic [7:0] mask;
    logic [7:0] data;

    assign bit_val = opnd_a[bit_pos];
    assign mask = opnd_b[15:8];
    assign data = opnd_b[7:0];

    // New register value for each class that rewrites its operand
    always_comb begin
        new_val = opnd_a;
        case (op)
            OP_JBS: new_val[bit_pos] = variant ? 1'b0 : bit_val;
            OP_JBC: new_val[bit_pos] = variant ? 1'b1 : bit_val;
            OP_MASK: begin
                if (variant) begin
                    new_val[15:8] = (opnd_a[15:8] & ~mask) | (data & mask);
                end else begin
                    new_val[7:0] = (opnd_a[7:0] & ~mask) | (data & mask);
                end
            end
            OP_WIDEN: new_val = variant ? {8'h00, data} : {{8{data[7]}}, data};
            OP_ARITH_SHIFT_RIGHT_OP: new_val = 16'($signed(opnd_a) >>> opnd_b[3:0]);
            OP_INV: new_val = variant ? {opnd_a[15:8], ~opnd_a[7:0]} : ~opnd_a;
            default: new_val = opnd_a;
        endcase
    end
endmodule

// ===== cpu_instruction_semantics.sv
// Instruction decode and execute semantics of the 16-bit core
// How it works
// (RQ1) Multiply two 16-bit registers, signed or unsigned, into the pair.
// (RQ2) Short divide: low half of pair by a 16-bit register, signed or not.
// (RQ3) Long divide: whole 32-bit pair by a 16-bit register, signed or not.
// (RQ4) Compare word with register, then decrement register by one or two.
// (RQ5) Compare word with register, then increment register by one or two.
// (RQ6) Branch when bit is one; clearing variant also clears it; 4 bytes.
// (RQ7) Branch when bit is zero; setting variant also sets it.
// (RQ8) Modify high or low byte under mask with immediate data; 4 bytes.
// (RQ9) Widen byte to word by sign or zero extension; 2 or 4 bytes.
// (RQ10) Arithmetic shift right replicating sign bit; 2 bytes.
// (RQ11) Push register then call absolute subroutine; 4 bytes.
// (RQ12) Push register then load it with word operand; 4 bytes.
// (RQ13) Return from subroutine; pop variant also pops a register; 2 bytes.
// (RQ14) Trap enters routine chosen by immediate trap number; 2 bytes.
// (RQ15) Init lock instruction locks protected registers for good; 4 bytes.
// (RQ16) Four-byte instructions disable, enable and service the watchdog.
// (RQ17) Complement inverts every bit of word or byte register; 2 bytes.
// (RQ18) Old power-down opcode is legal, 4 bytes, and does nothing.
// (RQ19) Every instruction reports a length of 2 or 4 bytes.
`timescale 1ns/10ps
module cpu_instruction_semantics import cpu_instr_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire instr_t instr,
    input wire core_t core,
    output logic instr_ready,
    output logic result_valid,
    output res_t result,
    output logic init_locked,
    output logic wdt_enabled,
    output logic wdt_service
);
    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta;
    logic rst_core_n;

    // Release is synchronised so no flop leaves reset on a different edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_core_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_core_n <= rst_meta;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } state_t;

    state_t state;
    op_t op;
    logic variant;
    logic long_form;
    logic known;
    logic accept;
    logic is_md;
    logic bit_val;
    logic [15:0] new_val;
    logic [15:0] step;
    logic [15:0] diff;
    res_t next_res;
    instr_t req_q;
    core_t core_q;
    logic md_busy;
    logic md_done;
    logic [31:0] md_out;
    logic md_zero;
    md_mode_t md_mode;

    assign op = op_t'(instr.opcode[7:OPC_CLASS_LSB]);
    assign variant = instr.opcode[OPC_VARIANT_BIT];
    assign long_form = instr.opcode[OPC_LONG_BIT];
    assign known = instr.opcode[7:OPC_CLASS_LSB] <= OP_INERT_POWERDOWN_OP;
    assign is_md = known && (op == OP_MUL || op == OP_DIV || op == OP_DIVL);
    assign instr_ready = state == ST_IDLE;
    assign accept = instr_valid && instr_ready;
    assign step = variant ? STEP_TWO : STEP_ONE;
    assign diff = instr.opnd_a - instr.opnd_b;

    // Fixed lengths; classes with two forms pick by the long-form bit
    function automatic logic len_is4(input op_t o, input logic lf);
        case (o)
            OP_CMPD, OP_CMPI, OP_WIDEN: len_is4 = lf;
            OP_JBS, OP_JBC, OP_MASK, OP_PUSH_AND_CALL_OP, OP_CTXSW: len_is4 = 1'b1;
            OP_INIT, OP_WDT, OP_WDTSRV, OP_INERT_POWERDOWN_OP: len_is4 = 1'b1;
            default: len_is4 = 1'b0;
        endcase
    endfunction

    bit_field_unit u_bits (
        .op(op),
        .variant(variant),
        .opnd_a(instr.opnd_a),
        .opnd_b(instr.opnd_b),
        .bit_pos(instr.bit_pos),
        .bit_val(bit_val),
        .new_val(new_val)
    );

    // ****************************************
    // Multiply and divide
    // ****************************************
    always_comb begin
        case (op)
            OP_DIV: md_mode = MD_DIV;
            OP_DIVL: md_mode = MD_DIVL;
            default: md_mode = MD_MUL;
        endcase
    end

    // Variant bit set selects the unsigned form
    muldiv_unit u_md (
        .clk_sys(clk_sys),
        .rst_core_n(rst_core_n),
        .start(accept && is_md), // RQ1 RQ2 RQ3
        .mode(md_mode),
        .is_signed(!variant),
        .md_in(core.muldiv_pair),
        .opnd_a(instr.opnd_a),
        .opnd_b(instr.opnd_b),
        .busy(md_busy),
        .done(md_done),
        .md_out(md_out),
        .div_zero(md_zero)
    );

    // ****************************************
    // Execute
    // ****************************************
    // Effects of one instruction, built from the offered operands
    always_comb begin
        next_res = '0;
        next_res.len4 = len_is4(op, long_form); // RQ19
        next_res.illegal = !known;
        next_res.target = instr.opnd_b;
        if (known) begin
            case (op)
                OP_CMPD, OP_CMPI: begin
                    next_res.flag_eq = diff == 16'h0000;
                    next_res.flag_neg = diff[15];
                    next_res.flag_carry = instr.opnd_a < instr.opnd_b;
                    next_res.wr_reg = 1'b1;
                    if (op == OP_CMPD) begin
                        next_res.reg_val = instr.opnd_a - step; // RQ4
                    end else begin
                        next_res.reg_val = instr.opnd_a + step; // RQ5
                    end
                end
                OP_JBS: begin
                    next_res.branch = bit_val; // RQ6
                    next_res.wr_reg = variant && bit_val;
                    next_res.reg_val = new_val;
                end
                OP_JBC: begin
                    next_res.branch = !bit_val; // RQ7
                    next_res.wr_reg = variant && !bit_val;
                    next_res.reg_val = new_val;
                end
                OP_MASK, OP_WIDEN, OP_ARITH_SHIFT_RIGHT_OP, OP_INV: begin
                    next_res.wr_reg = 1'b1; // RQ8 RQ9 RQ10 RQ17
                    next_res.reg_val = new_val;
                end
                OP_PUSH_AND_CALL_OP: begin
                    next_res.push = 1'b1; // RQ11
                    next_res.push_val = instr.opnd_a;
                    next_res.branch = 1'b1;
                end
                OP_CTXSW: begin
                    next_res.push = 1'b1; // RQ12
                    next_res.push_val = instr.opnd_a;
                    next_res.wr_reg = 1'b1;
                    next_res.reg_val = instr.opnd_b;
                end
                OP_RET: begin
                    // Return address comes off first, then the saved register
                    next_res.branch = 1'b1; // RQ13
                    next_res.target = core.stack_top;
                    next_res.pop_cnt = variant ? 2'b10 : 2'b01;
                    next_res.wr_reg = variant;
                    next_res.reg_val = core.stack_next;
                end
                OP_TRAP: begin
                    next_res.trap = 1'b1; // RQ14
                    next_res.trap_num = instr.imm;
                end
                default: next_res.target = instr.opnd_b; // RQ18
            endcase
        end
    end

    // Handshake state; the port stays closed while a divide iterates
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: state <= (accept && is_md) ? ST_WAIT : ST_IDLE;
                ST_WAIT: state <= md_done ? ST_IDLE : ST_WAIT;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Request and core state held for the whole instruction
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            req_q <= '0;
            core_q <= '0;
        end else if (accept) begin
            req_q <= instr;
            core_q <= core;
        end
    end

    // Result register; one pulse of result_valid per instruction
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            result_valid <= 1'b0;
            result <= '0;
        end else begin
            result_valid <= 1'b0;
            if (accept && !is_md) begin
                result_valid <= 1'b1;
                result <= next_res;
            end else if (accept) begin
                result <= next_res;
            end else if (state == ST_WAIT && md_done) begin
                result_valid <= 1'b1;
                result.wr_md <= !md_zero;
                result.md_val <= md_out;
                result.div_zero <= md_zero;
            end
        end
    end

    // ****************************************
    // System side effects
    // ****************************************
    // Lock is sticky: only a reset opens the protected registers again
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            init_locked <= INIT_LOCK_RESET;
        end else if (accept && known && op == OP_INIT) begin
            init_locked <= 1'b1; // RQ15
        end
    end

    // Watchdog runs from reset; variant one enables, zero disables
    always_ff @(posedge clk_sys or negedge rst_core_n) begin
        if (!rst_core_n) begin
            wdt_enabled <= WDT_ON_RESET;
            wdt_service <= 1'b0;
        end else begin
            wdt_service <= accept && known && op == OP_WDTSRV; // RQ16
            if (accept && known && op == OP_WDT) begin
                wdt_enabled <= variant; // RQ16
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_core_n);

    logic cur_bit;
    assign cur_bit = instr.opnd_a[instr.bit_pos];

    a_mul_product: assert property (result_valid && req_q.opcode[7:3] == OP_MUL // RQ1
        && req_q.opcode[0] |-> result.md_val == req_q.opnd_a * req_q.opnd_b)
        else $error("unsigned product wrong");
    a_div_short: assert property (result_valid && req_q.opcode[7:3] == OP_DIV // RQ2
        && req_q.opcode[0] && !result.div_zero
        |-> result.md_val[15:0] == core_q.muldiv_pair[15:0] / req_q.opnd_a)
        else $error("short quotient wrong");
    a_div_long: assert property (result_valid && req_q.opcode[7:3] == OP_DIVL // RQ3
        && req_q.opcode[0] && !result.div_zero
        |-> result.md_val[15:0] == 16'(core_q.muldiv_pair / {16'h0000, req_q.opnd_a}))
        else $error("long quotient wrong");
    a_div_ends: assert property (accept && is_md |-> ##[1:36] result_valid) // RQ2
        else $error("divide never finished");
    a_cmp_dec: assert property (accept && known && op == OP_CMPD // RQ4
        |=> result_valid && result.reg_val == $past(instr.opnd_a) - $past(step))
        else $error("decrement wrong");
    a_cmp_inc: assert property (accept && known && op == OP_CMPI // RQ5
        |=> result_valid && result.reg_val == $past(instr.opnd_a) + $past(step)
        && result.flag_eq == ($past(instr.opnd_a) == $past(instr.opnd_b)))
        else $error("increment or compare wrong");
    a_jmp_set: assert property (accept && known && op == OP_JBS // RQ6
        |=> result.branch == $past(cur_bit) && result.len4
        && result.wr_reg == ($past(cur_bit) && $past(variant)))
        else $error("bit set jump wrong");
    a_jmp_clear: assert property (accept && known && op == OP_JBC // RQ7
        |=> result.branch == !$past(cur_bit) && result.wr_reg == (!$past(cur_bit) && $past(variant)))
        else $error("bit clear jump wrong");
    a_mask_keeps: assert property (result_valid && req_q.opcode[7:3] == OP_MASK // RQ8
        && req_q.opcode[0] |-> result.reg_val[7:0] == req_q.opnd_a[7:0] && result.len4)
        else $error("masked modify touched other byte");
    a_widen_sign: assert property (result_valid && req_q.opcode[7:3] == OP_WIDEN // RQ9
        && !req_q.opcode[0] |-> result.reg_val == {{8{req_q.opnd_b[7]}}, req_q.opnd_b[7:0]})
        else $error("sign extension wrong");
    a_arith_shift_right_op_sign: assert property (result_valid && req_q.opcode[7:3] == OP_ARITH_SHIFT_RIGHT_OP // RQ10
        |-> result.reg_val[15] == req_q.opnd_a[15] && !result.len4)
        else $error("shift lost sign");
    a_push_and_call_op_push: assert property (result_valid && req_q.opcode[7:3] == OP_PUSH_AND_CALL_OP // RQ11
        |-> result.push && result.branch && result.push_val == req_q.opnd_a
        && result.target == req_q.opnd_b)
        else $error("push and call wrong");
    a_ctx_swap: assert property (result_valid && req_q.opcode[7:3] == OP_CTXSW // RQ12
        |-> result.push && result.push_val == req_q.opnd_a && result.reg_val == req_q.opnd_b)
        else $error("context switch wrong");
    a_ret_pop: assert property (result_valid && req_q.opcode[7:3] == OP_RET // RQ13
        |-> result.target == core_q.stack_top && result.pop_cnt == {req_q.opcode[0], !req_q.opcode[0]})
        else $error("return wrong");
    a_trap_num: assert property (result_valid && req_q.opcode[7:3] == OP_TRAP // RQ14
        |-> result.trap && result.trap_num == req_q.imm && !result.len4)
        else $error("trap number wrong");
    a_init_sticky: assert property (init_locked |=> init_locked) // RQ15
        else $error("init lock released");
    a_wdt_switch: assert property (accept && known && op == OP_WDT // RQ16
        |=> wdt_enabled == $past(variant) && !wdt_service)
        else $error("watchdog switch wrong");
    a_inv_word: assert property (result_valid && req_q.opcode[7:3] == OP_INV // RQ17
        && !req_q.opcode[0] |-> result.reg_val == ~req_q.opnd_a)
        else $error("complement wrong");
    a_inert_powerdown_op_inert: assert property (accept && known && op == OP_INERT_POWERDOWN_OP // RQ18
        |=> result_valid && result.len4 && !result.illegal && !result.wr_reg
        && !result.branch && !result.push && $stable(wdt_enabled) && $stable(init_locked))
        else $error("power-down opcode acted");
    a_len_short: assert property (result_valid && req_q.opcode[7:3] <= OP_DIVL // RQ19
        |-> !result.len4)
        else $error("length wrong");

    c_divide_long: cover property (accept && op == OP_DIVL ##[1:36] result_valid);
    c_jump_clear: cover property (accept && op == OP_JBS && variant && cur_bit);
    c_init_lock: cover property ($rose(init_locked));
    c_back_to_back: cover property (accept ##1 accept);
endmodule

// ===== fetch_model.sv
// Fetch side model that offers one instruction at a time with the core state
`timescale 1ns/10ps
module fetch_model import cpu_instr_pkg::*; (
    input wire logic clk_sys,
    input wire logic instr_ready,
    output logic instr_valid,
    output instr_t instr,
    output core_t core
);
    // Quiet lines at time zero
    initial begin
        instr_valid = 1'b0;
        instr = '0;
        core = '0;
    end
    // Hold the request until an edge sees ready; ready is combinational, so sample it early
    task automatic issue(input instr_t i, input core_t c);
        logic ok;
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr <= i;
        core <= c;
        do begin
            @(negedge clk_sys);
            ok = instr_ready;
            @(posedge clk_sys);
        end while (ok !== 1'b1);
        instr_valid <= 1'b0;
        instr <= ~i; // Released lines show a changed pattern
    endtask
endmodule

// ===== cpu_instruction_semantics_tb.sv
// Self-checking testbench of the instruction semantics block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module cpu_instruction_semantics_tb import cpu_instr_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid, instr_ready, result_valid, init_locked, wdt_enabled, wdt_service;
    instr_t instr;
    core_t core;
    res_t result;
    int error_cnt = 0;
    int checks = 0;
    // ****************************************
    // Clock, partner and device
    // ****************************************
    always #50 clk_sys = ~clk_sys;
    fetch_model fm_u(.clk_sys, .instr_ready, .instr_valid, .instr, .core);
    cpu_instruction_semantics dut_u(.clk_sys, .rst_n, .instr_valid, .instr, .core,
        .instr_ready, .result_valid, .result, .init_locked, .wdt_enabled, .wdt_service);
    // Issue one instruction and wait, bounded, for its result pulse
    task automatic op(input op_t c, input logic lg, v, input logic [15:0] a, b,
        input logic [7:0] im, input logic [31:0] md, input logic el);
        int n = 0;
        fm_u.issue('{{c, 1'b0, lg, v}, a, b, 4'h7, im}, '{md, 16'h1234, 16'h5678});
        while (result_valid !== 1'b1 && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK("result_valid", 1'b1, result_valid)
        `CHK("len4", el, result.len4)
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_muldiv;
        op(OP_MUL, 1'b0, 1'b0, 16'hFFFD, 16'h0005, 8'h00, 32'h0000_0000, 1'b0);
        `CHK("mul_s", 32'hFFFF_FFF1, result.md_val)
        op(OP_MUL, 1'b0, 1'b1, 16'hFFFF, 16'h0002, 8'h00, 32'h0000_0000, 1'b0);
        `CHK("multiply_op", 32'h0001_FFFE, result.md_val)
        op(OP_DIV, 1'b0, 1'b0, 16'h0002, 16'h0000, 8'h00, 32'hAAAA_FFF9, 1'b0);
        `CHK("div_s", 32'hFFFF_FFFD, result.md_val)
        op(OP_DIVL, 1'b0, 1'b1, 16'h0002, 16'h0000, 8'h00, 32'h0001_0003, 1'b0);
        `CHK("long_divide_op", 32'h0001_8001, result.md_val)
        op(OP_DIV, 1'b0, 1'b1, 16'h0000, 16'h0000, 8'h00, 32'h1234_5678, 1'b0);
        `CHK("div0", 33'h1_1234_5678, {result.div_zero, result.md_val})
    endtask
    task automatic t_compare;
        op(OP_CMPD, 1'b1, 1'b0, 16'h0010, 16'h0010, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("cmpd", 17'h1_000F, {result.flag_eq, result.reg_val})
        op(OP_CMPI, 1'b0, 1'b1, 16'hFFFF, 16'h0010, 8'h00, 32'h0000_0000, 1'b0);
        `CHK("cmpi", 17'h0_0001, {result.flag_eq, result.reg_val})
    endtask
    task automatic t_jump;
        op(OP_JBS, 1'b0, 1'b1, 16'h0080, 16'h0300, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("jbs", 33'h1_0000_0300, {result.branch, result.reg_val, result.target})
        op(OP_JBS, 1'b0, 1'b0, 16'h0000, 16'h0300, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("jbs_no", 1'b0, result.branch)
        op(OP_JBC, 1'b0, 1'b1, 16'h0000, 16'h0400, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("jbc", 33'h1_0080_0400, {result.branch, result.reg_val, result.target})
    endtask
    task automatic t_bits;
        op(OP_MASK, 1'b0, 1'b1, 16'h1234, 16'hF0AB, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("mask_hi", 16'hA234, result.reg_val)
        op(OP_WIDEN, 1'b0, 1'b0, 16'h0000, 16'h1280, 8'h00, 32'h0000_0000, 1'b0);
        `CHK("widen_s", 16'hFF80, result.reg_val)
        op(OP_WIDEN, 1'b1, 1'b1, 16'h0000, 16'h1280, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("widen_z", 16'h0080, result.reg_val)
        op(OP_ARITH_SHIFT_RIGHT_OP, 1'b0, 1'b0, 16'h8000, 16'h0004, 8'h00, 32'h0000_0000, 1'b0);
        `CHK("arith_shift_right_op", 16'hF800, result.reg_val)
        op(OP_INV, 1'b0, 1'b0, 16'h00FF, 16'h0000, 8'h00, 32'h0000_0000, 1'b0);
        `CHK("inv", 16'hFF00, result.reg_val)
    endtask
    task automatic t_stack;
        op(OP_PUSH_AND_CALL_OP, 1'b0, 1'b0, 16'h4321, 16'h0200, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("push_and_call_op", 33'h1_4321_0200, {result.push, result.push_val, result.target})
        op(OP_CTXSW, 1'b0, 1'b0, 16'h4321, 16'h0055, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("ctxsw", 33'h1_4321_0055, {result.push, result.push_val, result.reg_val})
        op(OP_RET, 1'b0, 1'b1, 16'h0000, 16'h0000, 8'h00, 32'h0000_0000, 1'b0);
        `CHK("retp", 34'h2_1234_5678, {result.pop_cnt, result.target, result.reg_val})
        op(OP_TRAP, 1'b0, 1'b0, 16'h0000, 16'h0000, 8'h2A, 32'h0000_0000, 1'b0);
        `CHK("trap", 9'h12A, {result.trap, result.trap_num})
    endtask
    task automatic t_system;
        `CHK("wdt_rst", 1'b1, wdt_enabled)
        op(OP_WDT, 1'b0, 1'b0, 16'h0000, 16'h0000, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("wdt_off", 1'b0, wdt_enabled)
        op(OP_WDTSRV, 1'b0, 1'b0, 16'h0000, 16'h0000, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("wdt_srv", 1'b1, wdt_service)
        `CHK("lock_rst", 1'b0, init_locked)
        op(OP_INIT, 1'b0, 1'b0, 16'h0000, 16'h0000, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("lock", 1'b1, init_locked)
        op(OP_INERT_POWERDOWN_OP, 1'b0, 1'b0, 16'h1111, 16'h2222, 8'h00, 32'h0000_0000, 1'b1);
        `CHK("inert_powerdown_op", 5'h00, {result.illegal, result.wr_reg, result.wr_md, result.push,
            result.branch})
    endtask
    // Print the counts and the verdict, then stop
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog well beyond the roughly 130 cycles the tests need
    initial begin
        #400_000;
        error_cnt++;
        end_of_test;
    end
    // Main sequence: reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_system;
        t_muldiv;
        t_compare;
        t_jump;
        t_bits;
        t_stack;
        end_of_test;
    end
endmodule
